// ### rtl/ake_key_extractor.sv
// Transport, payload, OAM and custom key field extractor with a Wishbone register slave.
//
// Functional notes
// - Eight-bit range mask, one bit per checker.
// - VID/DSCP from classifier, ports/custom from frame.
// - Flag set when source port equals destination.
// - Flag set when TCP sequence is zero.
// - 96-bit IP payload, IPv4 fixed 20 bytes.
// - 64-bit payload after TRANSPORT_IS_A header.
// - Seven-tuple non-transport uses IP payload bytes.
// - Flag when CCM loss counters all zero.
// - OAM EtherType flag; field carries MEL flags.
// - 57-byte custom field from frame pointer.
// - Ethernet frames: custom starts after Ethernet layer.
// - 24-byte custom field at classifier location.
// - Protocol 6 or 17 marks transport frame.
`timescale 1ns/1ps
`include "ake_params.svh"

module ake_key_extractor (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      inValid,
  input  wire logic [1023:0]             frameBytes,
  input  wire logic                      isEth,
  input  wire logic [6:0]                ethLayerEnd,
  input  wire logic                      isIp,
  input  wire logic                      isIpv4,
  input  wire logic [6:0]                ipStart,
  input  wire logic [7:0]                ipProto,
  input  wire logic [6:0]                l4Start,
  input  wire logic [6:0]                widePtr,
  input  wire logic [6:0]                narrowPtr,
  input  wire logic                      sevenTupleKey,
  input  wire logic [11:0]               classVid,
  input  wire logic [5:0]                classDscp,
  output logic                           keyValid,
  output logic [7:0]                     portRangeMask,
  output logic                           portsEqualFlag,
  output logic                           seqZeroFlag,
  output logic                           tcpCloseBit,
  output logic                           tcpSyncBit,
  output logic                           tcpAbortBit,
  output logic                           tcpPushBit,
  output logic                           tcpAcknowledgeBit,
  output logic                           tcpUrgentBit,
  output logic                           transportIsA,
  output logic [95:0]                    ipPayloadBytes,
  output logic [63:0]                    transportPayloadBytes,
  output logic                           lossCountersZeroFlag,
  output logic                           oamEthertypeFlag,
  output logic [15:0]                    ethertypeField,
  output logic [455:0]                   customWidePayload,
  output logic [191:0]                   customNarrowPayload
);
  import ake_pkg::*;

  // Returns the frame buffer shifted so that byte idx lands in bits 7:0.
  function automatic logic [1023:0] fromByte(input logic [1023:0] buf_, input logic [6:0] idx);
    fromByte = buf_ >> {idx, 3'h0};
  endfunction

  logic [31:0]             rngBound_q [`AKE_RNG_CNT];
  ake_range_kind_type      rngKind_q  [`AKE_RNG_CNT];
  logic                    ack_q;
  logic [31:0]             rdat_q;
  logic                    keyValid_q;

  // Bus decode: bounds, kinds and the read-only status word.
  wire         busReq    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire [2:0]   regIdx    = wb_adr_i[4:2];
  wire         hitBound  = wb_adr_i[7:5] == 3'(`AKE_BOUND_BASE >> 5);
  wire         hitKind   = wb_adr_i[7:5] == 3'(`AKE_TYPE_BASE >> 5);
  wire         hitStatus = wb_adr_i[7:2] == 6'(`AKE_STATUS_ADR >> 2);
  wire [31:0]  statusWord = {16'h0, portRangeMask, 2'h0, keyValid_q, transportIsA,
                             oamEthertypeFlag, lossCountersZeroFlag, seqZeroFlag, portsEqualFlag};
  wire [31:0]  readMux   = hitBound  ? rngBound_q[regIdx] :
                           hitKind   ? {29'h0, rngKind_q[regIdx]} :
                           hitStatus ? statusWord : 32'h0;

  // Classic single-cycle acknowledge; unmapped reads return zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= busReq;
      rdat_q <= readMux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Register writes honour the byte lanes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `AKE_RNG_CNT; i++) begin
        rngBound_q[i] <= `AKE_BOUND_RST;
        rngKind_q[i]  <= RNG_OFF;
      end
    end else if (busReq && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (hitBound && wb_sel_i[b]) begin
          rngBound_q[regIdx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
      if (hitKind && wb_sel_i[0]) begin
        rngKind_q[regIdx] <= ake_range_kind_type'(wb_dat_i[2:0]);
      end
    end
  end

  // Transport header fields read from the frame.
  wire [1023:0] l4Win     = fromByte(frameBytes, l4Start);
  wire [15:0]   srcPort   = {l4Win[7:0], l4Win[15:8]};
  wire [15:0]   dstPort   = {l4Win[23:16], l4Win[31:24]};
  wire [31:0]   seqNum    = l4Win[`AKE_TCP_SEQ*8 +: 32];
  wire [7:0]    tcpFlags  = l4Win[`AKE_TCP_FLAGS*8 +: 8];
  wire [6:0]    tcpHdrLen = {l4Win[103:100], 2'h0} + 7'h0;
  wire          isTcp     = isIp && ipProto == `AKE_PROTO_TCP;
  wire          isL4      = isTcp || (isIp && ipProto == `AKE_PROTO_UDP);

  // Payload starts: IPv4 options are never parsed.
  // fixed IPv4 offset
  wire [6:0]    ipPayStart = ipStart + (isIpv4 ? `AKE_IPV4_HDR : `AKE_IPV6_HDR);
  wire [6:0]    l4PayStart = l4Start + (isTcp ? tcpHdrLen : `AKE_UDP_HDR);
  wire [1023:0] ipPayWin   = fromByte(frameBytes, ipPayStart);
  wire [1023:0] l4PayWin   = fromByte(frameBytes, l4PayStart);

  // Custom windows never start inside the Ethernet layer.
  // skip Ethernet layer
  wire [6:0]    wideStart   = (isEth && widePtr < ethLayerEnd) ? ethLayerEnd : widePtr;
  wire [6:0]    narrowStart = (isEth && narrowPtr < ethLayerEnd) ? ethLayerEnd : narrowPtr;
  wire [1023:0] wideWin     = fromByte(frameBytes, wideStart);
  wire [1023:0] narrowWin   = fromByte(frameBytes, narrowStart);
  wire [15:0]   customVal   = {wideWin[7:0], wideWin[15:8]};

  // OAM detection on the EtherType closing the Ethernet layer.
  wire [1023:0] oamWin   = fromByte(frameBytes, ethLayerEnd);
  wire [1023:0] etWin    = fromByte(frameBytes, ethLayerEnd - 7'h2);
  wire [15:0]   etherType = {etWin[7:0], etWin[15:8]};
  wire          isOam    = isEth && etherType == `AKE_OAM_ETHERTYPE_FIELD;
  wire [2:0]    oamMel   = oamWin[7:5];
  wire [7:0]    melOneHot = 8'h1 << oamMel;
  wire          isCcm    = isOam && oamWin[15:8] == `AKE_CCM_OPCODE;
  wire          cntsZero = isCcm && oamWin[`AKE_CCM_CNT_OFS*8 +: 96] == 96'h0;

  // Range checkers compare against bounds {high, low}.
  logic [7:0] rngHit;
  always_comb begin
    rngHit = 8'h0;
    for (int i = 0; i < `AKE_RNG_CNT; i++) begin
      case (rngKind_q[i])
        RNG_SPORT: rngHit[i] = isL4 && srcPort >= rngBound_q[i][15:0] && srcPort <= rngBound_q[i][31:16];
        RNG_DPORT: rngHit[i] = isL4 && dstPort >= rngBound_q[i][15:0] && dstPort <= rngBound_q[i][31:16];
        RNG_EITHER: rngHit[i] = isL4 && ((srcPort >= rngBound_q[i][15:0] && srcPort <= rngBound_q[i][31:16])
                                || (dstPort >= rngBound_q[i][15:0] && dstPort <= rngBound_q[i][31:16]));
        RNG_VID: rngHit[i] = {4'h0, classVid} >= rngBound_q[i][15:0] && {4'h0, classVid} <= rngBound_q[i][31:16];
        RNG_DSCP: rngHit[i] = {10'h0, classDscp} >= rngBound_q[i][15:0]
                              && {10'h0, classDscp} <= rngBound_q[i][31:16];
        RNG_CUSTOM: rngHit[i] = customVal >= rngBound_q[i][15:0] && customVal <= rngBound_q[i][31:16];
        default: rngHit[i] = 1'b0;
      endcase
    end
  end

  // Key fields are captured on each valid input and held until the next.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      keyValid_q            <= 1'b0;
      portRangeMask         <= 8'h0;
      portsEqualFlag        <= 1'b0;
      seqZeroFlag           <= 1'b0;
      {tcpUrgentBit, tcpAcknowledgeBit, tcpPushBit, tcpAbortBit, tcpSyncBit, tcpCloseBit} <= 6'h0;
      transportIsA          <= 1'b0;
      ipPayloadBytes        <= 96'h0;
      transportPayloadBytes <= 64'h0;
      lossCountersZeroFlag  <= 1'b0;
      oamEthertypeFlag      <= 1'b0;
      ethertypeField        <= 16'h0;
      customWidePayload     <= 456'h0;
      customNarrowPayload   <= 192'h0;
    end else begin
      keyValid_q <= inValid;
      if (inValid) begin
        portRangeMask         <= rngHit;
        portsEqualFlag        <= isL4 && srcPort == dstPort;
        seqZeroFlag           <= isTcp && seqNum == 32'h0;
        {tcpUrgentBit, tcpAcknowledgeBit, tcpPushBit, tcpAbortBit, tcpSyncBit, tcpCloseBit}
                              <= isTcp ? tcpFlags[5:0] : 6'h0;
        transportIsA          <= isL4;
        ipPayloadBytes        <= isIp ? ipPayWin[95:0] : 96'h0;
        transportPayloadBytes <= isL4 ? l4PayWin[63:0] : (sevenTupleKey && isIp) ? ipPayWin[63:0] : 64'h0;
        lossCountersZeroFlag  <= cntsZero;
        oamEthertypeFlag      <= isOam;
        ethertypeField        <= isOam ? {8'h0, melOneHot} : etherType;
        customWidePayload     <= wideWin[455:0];
        customNarrowPayload   <= narrowWin[191:0];
      end
    end
  end

  assign keyValid = keyValid_q;

  // Checks on the captured key against the inputs of the previous cycle or against other key fields, and on the bus acknowledge.
  sequence s_inTcp;
    inValid && isIp && ipProto == `AKE_PROTO_TCP;
  endsequence

  a_ports_equal: assert property (@(posedge clk) disable iff (!rstn)
    inValid |=> portsEqualFlag == ($past(isL4) && $past(srcPort) == $past(dstPort)))
    else $error("ports equal flag wrong");
  a_seq_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_inTcp ##0 seqNum == 32'h0 |=> seqZeroFlag && keyValid)
    else $error("sequence zero flag missing");
  a_tcp_flags: assert property (@(posedge clk) disable iff (!rstn)
    s_inTcp |=> {tcpUrgentBit, tcpSyncBit, tcpCloseBit} == {$past(tcpFlags[5]), $past(tcpFlags[1:0])})
    else $error("tcp flags not copied");
  a_transport_type: assert property (@(posedge clk) disable iff (!rstn)
    inValid && isIp && (ipProto == 8'h06 || ipProto == 8'h11) |=> transportIsA)
    else $error("transport flag not set");
  a_ip_payload: assert property (@(posedge clk) disable iff (!rstn)
    inValid && isIp && isIpv4 |=> ipPayloadBytes[7:0] == $past(frameBytes[(ipStart + 7'h14)*8 +: 8]))
    else $error("ip payload offset wrong");
  a_seven_tuple: assert property (@(posedge clk) disable iff (!rstn)
    inValid && isIp && !isL4 && sevenTupleKey |=> transportPayloadBytes == ipPayloadBytes[63:0])
    else $error("seven tuple payload wrong");
  a_oam_ethertype_field: assert property (@(posedge clk) disable iff (!rstn)
    oamEthertypeFlag |-> ethertypeField[15:8] == 8'h0 && $onehot(ethertypeField[7:0]))
    else $error("oam ethertype field not overloaded");
  a_loss_zero: assert property (@(posedge clk) disable iff (!rstn)
    lossCountersZeroFlag |-> oamEthertypeFlag)
    else $error("loss flag without oam frame");
  a_wide_start: assert property (@(posedge clk) disable iff (!rstn)
    inValid && isEth && widePtr < ethLayerEnd |=> customWidePayload[7:0] == $past(oamWin[7:0]))
    else $error("custom payload inside ethernet layer");
  a_range_off: assert property (@(posedge clk) disable iff (!rstn)
    inValid && rngKind_q[0] == RNG_OFF |=> !portRangeMask[0])
    else $error("disabled range checker hit");
  a_bus_ack: assert property (@(posedge clk) disable iff (!rstn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");
  // The acknowledge is a single-cycle pulse even if the request is held.
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");

  // Checks on the key valid pulse, on fields taken straight from the frame and on the range mask.
  // key valid follows.
  a_key_valid: assert property (@(posedge clk) disable iff (!rstn)
    inValid |=> keyValid)
    else $error("key valid missing");
  a_key_idle: assert property (@(posedge clk) disable iff (!rstn)
    !inValid |=> !keyValid)
    else $error("key valid without input");
  a_transport_payload_bytes: assert property (@(posedge clk) disable iff (!rstn)
    inValid && isL4 && !isTcp |=> transportPayloadBytes[7:0] == $past(frameBytes[(l4Start + 7'h08)*8 +: 8]))
    else $error("transport payload offset wrong");
  a_wide_payload: assert property (@(posedge clk) disable iff (!rstn)
    inValid && !(isEth && widePtr < ethLayerEnd) |=> customWidePayload[7:0] == $past(frameBytes[widePtr*8 +: 8]))
    else $error("wide custom payload offset wrong");
  a_narrow_payload: assert property (@(posedge clk) disable iff (!rstn)
    inValid && !(isEth && narrowPtr < ethLayerEnd) |=> customNarrowPayload[7:0] == $past(frameBytes[narrowPtr*8 +: 8]))
    else $error("narrow custom payload offset wrong");
  a_oam_flag: assert property (@(posedge clk) disable iff (!rstn)
    inValid |=> oamEthertypeFlag == $past(isEth && frameBytes[(ethLayerEnd - 7'h2)*8 +: 16] == 16'h0289))
    else $error("oam ethertype flag wrong");
  a_vid_range: assert property (@(posedge clk) disable iff (!rstn)
    inValid && rngKind_q[2] == RNG_VID && rngBound_q[2] == 32'hffff0000 |=> portRangeMask[2])
    else $error("vid range checker missed");
  a_port_needs_l4: assert property (@(posedge clk) disable iff (!rstn)
    inValid && !isL4 && rngKind_q[0] == RNG_SPORT |=> !portRangeMask[0])
    else $error("port checker hit on non transport frame");
  a_tcp_only: assert property (@(posedge clk) disable iff (!rstn)
    inValid && !(isIp && ipProto == 8'h06)
    |=> {tcpUrgentBit, tcpAcknowledgeBit, tcpPushBit, tcpAbortBit, tcpSyncBit, tcpCloseBit} == 6'h0)
    else $error("tcp flags set on non tcp frame");

endmodule

// ### rtl/ake_params.svh
// Offsets, field positions, reset values and frame layout constants of the key extractor.
`ifndef AKE_PARAMS_SVH
`define AKE_PARAMS_SVH
`define AKE_BOUND_BASE  8'h00
`define AKE_TYPE_BASE   8'h20
`define AKE_STATUS_ADR  8'h40
`define AKE_BOUND_RST   32'hffff0000
`define AKE_BUF_BYTES   128
`define AKE_IPV4_HDR    7'h14
`define AKE_IPV6_HDR    7'h28
`define AKE_UDP_HDR     7'h08
`define AKE_OAM_ETHERTYPE_FIELD   16'h8902
`define AKE_PROTO_TCP   8'h06
`define AKE_PROTO_UDP   8'h11
`define AKE_CCM_OPCODE  8'h01
`define AKE_CCM_CNT_OFS 7'h3a
`define AKE_TCP_FLAGS   7'h0d
`define AKE_TCP_SEQ     7'h04
`define AKE_RNG_CNT     8
`endif

// ### rtl/ake_pkg.sv
// Types shared by the key extractor and its bench.
package ake_pkg;
  typedef enum logic [2:0] {RNG_OFF, RNG_SPORT, RNG_DPORT, RNG_EITHER,
                            RNG_VID, RNG_DSCP, RNG_CUSTOM} ake_range_kind_type;
endpackage

// ### testbench/ake_frame_model.sv
// Frame source model: the parser side that presents frame bytes to the extractor.
`timescale 1ns/1ps
module ake_frame_model (
  output logic [1023:0] frameBytes
);
  logic [7:0] mem [0:127];
  // Byte n of the frame travels in bits 8n+7 down to 8n.
  always_comb begin
    for (int n = 0; n < 128; n++) begin
      frameBytes[8*n +: 8] = mem[n];
    end
  end
  // Fills the frame with a pattern that differs from byte to byte.
  task automatic fill();
    for (int n = 0; n < 128; n++) begin
      mem[n] <= 8'(n) ^ 8'h5a;
    end
  endtask
  // Places one byte; later calls in one step win over the fill.
  task automatic put(input int idx, input logic [7:0] val);
    mem[idx] <= val;
  endtask
endmodule

// ### testbench/ake_key_extractor_tb_top.sv
// Bench for the key extractor: registers, transport, seven-tuple, OAM and custom frames.
`timescale 1ns/1ps
`include "ake_params.svh"
module ake_key_extractor_tb_top;
  import ake_pkg::*;
  logic          clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, inValid, isEth, isIp, isIpv4;
  logic          sevenTupleKey, keyValid, portsEqualFlag, seqZeroFlag, tcpCloseBit, tcpSyncBit;
  logic          tcpAbortBit, tcpPushBit, tcpAcknowledgeBit, tcpUrgentBit, transportIsA;
  logic          lossCountersZeroFlag, oamEthertypeFlag;
  logic [3:0]    wb_sel_i;
  logic [5:0]    classDscp;
  logic [6:0]    ethLayerEnd, ipStart, l4Start, widePtr, narrowPtr;
  logic [7:0]    wb_adr_i, ipProto, portRangeMask;
  logic [11:0]   classVid;
  logic [15:0]   ethertypeField;
  logic [31:0]   wb_dat_i, wb_dat_o, rd;
  logic [63:0]   transportPayloadBytes;
  logic [95:0]   ipPayloadBytes;
  logic [191:0]  customNarrowPayload;
  logic [455:0]  customWidePayload;
  logic [1023:0] frameBytes;
  int            bad_count, checks, cycles;
  ake_key_extractor ake_key_extractor_inst (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .inValid, .frameBytes, .isEth, .ethLayerEnd, .isIp,
    .isIpv4, .ipStart, .ipProto, .l4Start, .widePtr, .narrowPtr, .sevenTupleKey, .classVid, .classDscp,
    .keyValid, .portRangeMask, .portsEqualFlag, .seqZeroFlag, .tcpCloseBit, .tcpSyncBit, .tcpAbortBit,
    .tcpPushBit, .tcpAcknowledgeBit, .tcpUrgentBit, .transportIsA, .ipPayloadBytes, .transportPayloadBytes,
    .lossCountersZeroFlag, .oamEthertypeFlag, .ethertypeField, .customWidePayload, .customNarrowPayload);
  ake_frame_model ake_frame_model_inst (.frameBytes);
  // Clock of 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  // Compares a seen value with the expected one.
  task automatic check(input logic [455:0] seen, input logic [455:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("FAIL t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One classic Wishbone cycle; read data is taken at the edge that sees ack.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Presents the frame for one cycle; fields are looked at once keyValid is up.
  task automatic sendKey();
    @(posedge clk);
    inValid <= 1'b1;
    @(posedge clk);
    inValid <= 1'b0;
    #1;
    check(keyValid, 1'b1);
    @(posedge clk);
  endtask
  // Expected field: count frame bytes from start, first byte lowest.
  function automatic logic [455:0] bytesAt(input int start, input int count);
    bytesAt = '0;
    for (int i = 0; i < count; i++) begin
      bytesAt[8*i +: 8] = frameBytes[8*(start+i) +: 8];
    end
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ake_range_kind_type kinds [8] = '{RNG_SPORT, RNG_DPORT, RNG_VID, RNG_SPORT, RNG_EITHER, RNG_DSCP, RNG_CUSTOM, RNG_OFF};
  logic [31:0] bounds [8] = '{32'h13001200, 32'hffff0000, 32'hffff0000, 32'h30002000, 32'h0, 32'h0, 32'hffff0000, 32'h0};
  // Main sequence: reset, registers, then one frame kind after another.
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, inValid} = '0;
    {isEth, isIp, isIpv4, sevenTupleKey, ethLayerEnd, ipStart, l4Start, widePtr, narrowPtr} = '0;
    {ipProto, classVid, classDscp, bad_count, checks, cycles} = '0;
    wb_sel_i = 4'hf;
    ake_frame_model_inst.fill();
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    check(rd, `AKE_BOUND_RST);
    wb(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, `AKE_BOUND_BASE + 8'(4*i), bounds[i]);
      wb(1'b1, `AKE_TYPE_BASE + 8'(4*i), 32'(kinds[i]));
    end
    wb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h4);
    $display("test registers done");
    {isEth, isIp, isIpv4, sevenTupleKey, ethLayerEnd, ipStart, l4Start} <= {4'hf, 7'd14, 7'd14, 7'd34};
    {ipProto, widePtr, narrowPtr, classVid, classDscp} <= {`AKE_PROTO_TCP, 7'd4, 7'd60, 12'h00a, 6'h05};
    for (int i = 34; i < 42; i++) ake_frame_model_inst.put(i, (i < 38) ? ((i % 2) ? 8'h34 : 8'h12) : 8'h00);
    ake_frame_model_inst.put(46, 8'h50);
    ake_frame_model_inst.put(47, 8'h15);
    sendKey();
    check(portRangeMask, 8'h47);
    check(portsEqualFlag, 1'b1);
    check(seqZeroFlag, 1'b1);
    check({tcpUrgentBit, tcpAcknowledgeBit, tcpPushBit, tcpAbortBit, tcpSyncBit, tcpCloseBit}, 6'h15);
    check(transportIsA, 1'b1);
    check(ipPayloadBytes, bytesAt(34, 12));
    check(transportPayloadBytes, bytesAt(54, 8));
    check({oamEthertypeFlag, ethertypeField}, 17'h05657);
    check(customWidePayload, bytesAt(14, 57));
    check(customNarrowPayload, bytesAt(60, 24));
    wb(1'b0, `AKE_STATUS_ADR, 32'h0);
    check(rd, 32'h4713);
    $display("test tcp frame done");
    ipProto <= `AKE_PROTO_UDP;
    ake_frame_model_inst.put(37, 8'h35);
    sendKey();
    check({transportIsA, portsEqualFlag}, 2'b10);
    check(transportPayloadBytes, bytesAt(42, 8));
    ipProto <= 8'h01;
    sendKey();
    check({transportIsA, portRangeMask}, 9'h044);
    check(transportPayloadBytes, bytesAt(34, 8));
    $display("test udp and other done");
    {isIp, narrowPtr} <= {1'b0, 7'd2};
    for (int i = 72; i < 84; i++) ake_frame_model_inst.put(i, 8'h00);
    ake_frame_model_inst.put(12, 8'h89);
    ake_frame_model_inst.put(13, 8'h02);
    ake_frame_model_inst.put(14, 8'ha0);
    ake_frame_model_inst.put(15, `AKE_CCM_OPCODE);
    sendKey();
    check({oamEthertypeFlag, ethertypeField}, 17'h10020);
    check(lossCountersZeroFlag, 1'b1);
    check(customNarrowPayload, bytesAt(14, 24));
    ake_frame_model_inst.put(80, 8'h01);
    sendKey();
    check(lossCountersZeroFlag, 1'b0);
    $display("test oam frame done");
    report_and_stop();
  end
endmodule
